// [noise_shaping_gain_control.sv]
// noise-shaping mode and gain selection control for a pipeline converter
// assumes sampleClk and adcIn are synchronous to clk, sampleClk much slower
// assumes one register write carries a whole serial configuration word
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - shaping is off after reset; only the enable bit turns it on
// - with shaping on, trough centre lies midway between two coded corners
// - codes 0 to 7 give corners 0.250 up to 0.420 of sample rate
// - codes 8 to F give corners 0.000 up to 0.230 of sample rate
// - trough centre equals sample rate times mean of the two corners
// - shaping adds one sample clock of delay to the input signal path
// - with shaping on, output comes 15 sample clocks after conversion start
// - shaping fully active 4 sample clocks after the enabling write ends
// - after disable, plain data resumes one sample clock later
// - a selectable coarse gain of fixed 3.5 dB exists
// - fine gain programmable 0 to 6 dB in 0.5 dB steps
// - host programs gains serially; device starts at 0 dB gain
// - conversion starts on rising edge of the sample clock
// - with shaping off, samples emerge 14 sample clocks after capture
module noise_shaping_gain_control #(
  parameter int DATA_W = 11,
  parameter int ADDR_W = 4
) (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [31:0]       regWdata,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output logic      [31:0]       regRdata,
  input  wire logic              sampleClk,
  input  wire logic [DATA_W-1:0] adcIn,
  output logic      [DATA_W-1:0] dataOut,
  output logic                   dataValid,
  output logic                   dataShaped,
  output logic                   shapingActive,
  output logic      [3:0]        cornerFirst,
  output logic      [3:0]        cornerSecond,
  output logic      [10:0]       troughCenter,
  output logic                   coarseGainOn,
  output logic      [3:0]        fineGainSteps
);

  localparam int DEPTH = int'(noise_shaping_gain_control_pkg::LAT_SHAPED);

  typedef enum logic [1:0] {
    MODE_OFF     = 2'b00,
    MODE_PENDING = 2'b01,
    MODE_ON      = 2'b10
  } mode_t;

  typedef struct packed {
    logic                        shapeEn;
    logic                        coarse;
    logic [3:0]                  codeFirst;
    logic [3:0]                  codeSecond;
    logic [3:0]                  fine;
    mode_t                       mode;
    logic [2:0]                  actCount;
    logic                        sampleClkPrev;
    logic [DEPTH:1][DATA_W-1:0]  pipe;
    logic [DATA_W-1:0]           dataOut;
    logic                        dataValid;
    logic                        dataShaped;
    logic [10:0]                 center;
    logic [31:0]                 rdata;
  } state_t;

  state_t state_reg;
  state_t state_next;

  logic rstSync1;
  logic rstSync2;

  // reset released through two flops so the release is clean on clk
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rstSync1 <= 1'b0;
      rstSync2 <= 1'b0;
    end else begin
      rstSync1 <= 1'b1;
      rstSync2 <= rstSync1;
    end
  end

  // corner frequency in thousandths of the sample rate
  function automatic logic [9:0] cornerOf(input logic [3:0] code);
    cornerOf = noise_shaping_gain_control_pkg::CORNER_TABLE[code];
  endfunction : cornerOf

  // sum of two corners: the mean in half-thousandths of the sample rate
  function automatic logic [10:0] centerOf(input logic [3:0] a,
                                           input logic [3:0] b);
    centerOf = {1'b0, cornerOf(a)} + {1'b0, cornerOf(b)};
  endfunction : centerOf

  logic        sampleEdge;
  logic        wrCtrl;
  logic        wrCorner;
  logic        wrFine;
  logic        newEn;
  logic [3:0]  newFine;
  logic [3:0]  latency;
  logic [31:0] statusWord;

  assign sampleEdge = sampleClk & ~state_reg.sampleClkPrev;
  assign wrCtrl   = regWr &&
                    (regAddr == noise_shaping_gain_control_pkg::ADDR_CTRL);
  assign wrCorner = regWr &&
                    (regAddr == noise_shaping_gain_control_pkg::ADDR_CORNER);
  assign wrFine   = regWr &&
                    (regAddr == noise_shaping_gain_control_pkg::ADDR_FINE);
  assign newEn = regWdata[noise_shaping_gain_control_pkg::CTRL_SHAPE_EN_BIT];
  assign newFine =
    regWdata[noise_shaping_gain_control_pkg::FINE_LSB +:
             noise_shaping_gain_control_pkg::FINE_W];

  // output tap follows the mode actually in force, not the written bit
  assign latency = (state_reg.mode == MODE_ON) ?
                   noise_shaping_gain_control_pkg::LAT_SHAPED :
                   noise_shaping_gain_control_pkg::LAT_PLAIN;

  always_comb begin
    statusWord = 32'h0000_0000;
    statusWord[noise_shaping_gain_control_pkg::STAT_ACTIVE_BIT] =
      (state_reg.mode == MODE_ON);
    statusWord[noise_shaping_gain_control_pkg::STAT_PENDING_BIT] =
      (state_reg.mode == MODE_PENDING);
    statusWord[noise_shaping_gain_control_pkg::STAT_LAT_LSB +: 4] = latency;
    statusWord[noise_shaping_gain_control_pkg::STAT_CENTER_LSB +:
               noise_shaping_gain_control_pkg::CENTER_W] = state_reg.center;
  end

  always_comb begin
    state_next = state_reg;
    state_next.sampleClkPrev = sampleClk;
    state_next.dataValid = 1'b0;

    // register writes: a write strobe is the completed serial word, so
    // whole fields are taken at once and nothing half-written is applied
    if (wrCtrl) begin
      state_next.shapeEn = newEn;
      state_next.coarse =
        regWdata[noise_shaping_gain_control_pkg::CTRL_COARSE_BIT];
    end
    if (wrCorner) begin
      state_next.codeFirst =
        regWdata[noise_shaping_gain_control_pkg::CORNER_FIRST_LSB +:
                 noise_shaping_gain_control_pkg::CODE_W];
      state_next.codeSecond =
        regWdata[noise_shaping_gain_control_pkg::CORNER_SECOND_LSB +:
                 noise_shaping_gain_control_pkg::CODE_W];
    end
    if (wrFine) begin
      // codes past 6 dB saturate rather than wrap to a small gain
      state_next.fine =
        (newFine > noise_shaping_gain_control_pkg::FINE_MAX) ?
        noise_shaping_gain_control_pkg::FINE_MAX : newFine;
    end
    state_next.center = centerOf(state_next.codeFirst,
                                 state_next.codeSecond);

    // mode sequencing
    case (state_reg.mode)
      MODE_OFF: begin
        if (wrCtrl && newEn) begin
          state_next.mode = MODE_PENDING;
          state_next.actCount = noise_shaping_gain_control_pkg::ACT_DELAY;
        end
      end
      MODE_PENDING: begin
        if (wrCtrl && !newEn) begin
          state_next.mode = MODE_OFF;
        end else if (sampleEdge) begin
          if (state_reg.actCount == 3'h1) begin
            state_next.mode = MODE_ON;
          end
          state_next.actCount = state_reg.actCount - 3'h1;
        end
      end
      MODE_ON: begin
        // drop out on the first sample edge after the disabling write
        if (sampleEdge && !state_next.shapeEn) begin
          state_next.mode = MODE_OFF;
        end
      end
      default: begin
        state_next.mode = MODE_OFF;
      end
    endcase

    // sample pipeline: shaping changes the tap only, never the samples
    if (sampleEdge) begin
      state_next.pipe[1] = adcIn;
      for (int i = 2; i <= DEPTH; i++) begin
        state_next.pipe[i] = state_reg.pipe[i-1];
      end
      state_next.dataOut = state_reg.pipe[latency];
      state_next.dataValid = 1'b1;
      state_next.dataShaped = (state_reg.mode == MODE_ON);
    end

    // read data stands in the cycle after the strobe; unmapped reads zero
    state_next.rdata = 32'h0000_0000;
    if (regRd) begin
      case (regAddr)
        noise_shaping_gain_control_pkg::ADDR_CTRL: begin
          state_next.rdata[noise_shaping_gain_control_pkg::CTRL_SHAPE_EN_BIT] =
            state_reg.shapeEn;
          state_next.rdata[noise_shaping_gain_control_pkg::CTRL_COARSE_BIT] =
            state_reg.coarse;
        end
        noise_shaping_gain_control_pkg::ADDR_CORNER: begin
          state_next.rdata[noise_shaping_gain_control_pkg::CORNER_FIRST_LSB +:
                           noise_shaping_gain_control_pkg::CODE_W] =
            state_reg.codeFirst;
          state_next.rdata[noise_shaping_gain_control_pkg::CORNER_SECOND_LSB +:
                           noise_shaping_gain_control_pkg::CODE_W] =
            state_reg.codeSecond;
        end
        noise_shaping_gain_control_pkg::ADDR_FINE: begin
          state_next.rdata[noise_shaping_gain_control_pkg::FINE_LSB +:
                           noise_shaping_gain_control_pkg::FINE_W] =
            state_reg.fine;
        end
        noise_shaping_gain_control_pkg::ADDR_STATUS: begin
          state_next.rdata = statusWord;
        end
        default: begin
          state_next.rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstSync2) begin
    if (!rstSync2) begin
      state_reg.shapeEn       <= noise_shaping_gain_control_pkg::RST_SHAPE_EN;
      state_reg.coarse        <= noise_shaping_gain_control_pkg::RST_COARSE;
      state_reg.codeFirst     <= noise_shaping_gain_control_pkg::RST_CODE;
      state_reg.codeSecond    <= noise_shaping_gain_control_pkg::RST_CODE;
      state_reg.fine          <= noise_shaping_gain_control_pkg::RST_FINE;
      state_reg.mode          <= MODE_OFF;
      state_reg.actCount      <= 3'h0;
      state_reg.sampleClkPrev <= 1'b0;
      state_reg.pipe          <= '0;
      state_reg.dataOut       <= '0;
      state_reg.dataValid     <= 1'b0;
      state_reg.dataShaped    <= 1'b0;
      state_reg.center        <= noise_shaping_gain_control_pkg::RST_CENTER;
      state_reg.rdata         <= 32'h0000_0000;
    end else begin
      state_reg <= state_next;
    end
  end

  assign regRdata      = state_reg.rdata;
  assign dataOut       = state_reg.dataOut;
  assign dataValid     = state_reg.dataValid;
  assign dataShaped    = state_reg.dataShaped;
  assign shapingActive = (state_reg.mode == MODE_ON);
  assign cornerFirst   = state_reg.codeFirst;
  assign cornerSecond  = state_reg.codeSecond;
  assign troughCenter  = state_reg.center;
  assign coarseGainOn  = state_reg.coarse;
  assign fineGainSteps = state_reg.fine;

endmodule : noise_shaping_gain_control
`default_nettype wire

// [noise_shaping_gain_control_pkg.sv]
// constants shared by the noise-shaping and gain control block
// assumes a plain register port with four word registers at small indices
`default_nettype none
package noise_shaping_gain_control_pkg;

  // register indices on the plain register port
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_CORNER = 4'h1;
  localparam logic [3:0] ADDR_FINE   = 4'h2;
  localparam logic [3:0] ADDR_STATUS = 4'h3;

  // control register fields
  localparam int CTRL_SHAPE_EN_BIT = 0;
  localparam int CTRL_COARSE_BIT   = 1;
  // corner register fields
  localparam int CORNER_FIRST_LSB  = 0;
  localparam int CORNER_SECOND_LSB = 4;
  localparam int CODE_W            = 4;
  // fine gain field, in half-dB steps
  localparam int FINE_LSB          = 0;
  localparam int FINE_W            = 4;
  localparam logic [3:0] FINE_MAX  = 4'hC;
  // status register fields
  localparam int STAT_ACTIVE_BIT   = 0;
  localparam int STAT_PENDING_BIT  = 1;
  localparam int STAT_LAT_LSB      = 4;
  localparam int STAT_CENTER_LSB   = 8;
  localparam int CENTER_W          = 11;
  localparam int CORNER_W          = 10;

  // reset values
  localparam logic       RST_SHAPE_EN = 1'b0;
  localparam logic       RST_COARSE   = 1'b0;
  localparam logic [3:0] RST_CODE     = 4'h0;
  localparam logic [3:0] RST_FINE     = 4'h0;
  // both codes at 0 give corners of 250 thousandths each
  localparam logic [10:0] RST_CENTER  = 11'h1F4;

  // timing counts in sample-clock cycles
  localparam logic [3:0] LAT_PLAIN  = 4'hE;
  localparam logic [3:0] LAT_SHAPED = 4'hF;
  localparam logic [2:0] ACT_DELAY  = 3'h4;

  // corner frequency per code, in thousandths of the sample rate
  localparam logic [9:0] CORNER_TABLE [16] = '{
    10'h0FA, 10'h10E, 10'h122, 10'h137,
    10'h14D, 10'h165, 10'h181, 10'h1A4,
    10'h000, 10'h050, 10'h073, 10'h08F,
    10'h0A7, 10'h0BD, 10'h0D2, 10'h0E6
  };

endpackage : noise_shaping_gain_control_pkg
`default_nettype wire

// [noise_shaping_gain_control_props.sv]
// port assertions for the noise-shaping and gain control block
// assumes single clk domain, bound into every instance of the block
`timescale 1ns/1ps
`default_nettype none
module noise_shaping_gain_control_props #(
  parameter int ADDR_W = 4
) (
  input wire logic              clk,
  input wire logic              rst_b,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [31:0]       regWdata,
  input wire logic              regWr,
  input wire logic              regRd,
  input wire logic [31:0]       regRdata,
  input wire logic              dataValid,
  input wire logic              dataShaped,
  input wire logic              shapingActive,
  input wire logic [3:0]        cornerFirst,
  input wire logic [3:0]        cornerSecond,
  input wire logic [10:0]       troughCenter,
  input wire logic              coarseGainOn,
  input wire logic [3:0]        fineGainSteps
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire logic fineWr = regWr &&
    (regAddr == noise_shaping_gain_control_pkg::ADDR_FINE);
  wire logic ctrlWr = regWr &&
    (regAddr == noise_shaping_gain_control_pkg::ADDR_CTRL);
  wire logic cornWr = regWr &&
    (regAddr == noise_shaping_gain_control_pkg::ADDR_CORNER);
  // widened before the add so the sum of two corners cannot wrap
  wire logic [10:0] sumCorner =
    11'(noise_shaping_gain_control_pkg::CORNER_TABLE[cornerFirst]) +
    11'(noise_shaping_gain_control_pkg::CORNER_TABLE[cornerSecond]);
  rd_idle_a: assert property (!$past(regRd) |-> regRdata == 32'h0000_0000)
    else $error("read data not idle");
  fine_max_a: assert property (fineGainSteps <= 4'hC)
    else $error("fine gain above 6 dB");
  fine_wr_a: assert property (fineWr |=> fineGainSteps ==
    (($past(regWdata[3:0]) > 4'hC) ? 4'hC : $past(regWdata[3:0])))
    else $error("fine gain write not applied");
  fine_hold_a: assert property (!fineWr |=> $stable(fineGainSteps))
    else $error("fine gain moved without write");
  coarse_wr_a: assert property (ctrlWr |=> coarseGainOn == $past(regWdata[1]))
    else $error("coarse gain write not applied");
  coarse_hold_a: assert property (!ctrlWr |=> $stable(coarseGainOn))
    else $error("coarse gain moved without write");
  corner_wr_a: assert property (cornWr |=>
    {cornerSecond, cornerFirst} == $past(regWdata[7:0]))
    else $error("corner codes not applied");
  center_sum_a: assert property ($stable({cornerFirst, cornerSecond}) |->
    troughCenter == sumCorner)
    else $error("trough centre not mean of corners");
  valid_pulse_a: assert property (dataValid |=> !dataValid)
    else $error("sample valid longer than one cycle");
  cover property (fineWr);
  cover property ($rose(shapingActive));
  cover property (dataValid && dataShaped);
endmodule : noise_shaping_gain_control_props
bind noise_shaping_gain_control noise_shaping_gain_control_props #(
  .ADDR_W(ADDR_W)
) props_inst (
  .clk(clk), .rst_b(rst_b), .regAddr(regAddr), .regWdata(regWdata),
  .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
  .dataValid(dataValid), .dataShaped(dataShaped),
  .shapingActive(shapingActive), .cornerFirst(cornerFirst),
  .cornerSecond(cornerSecond), .troughCenter(troughCenter),
  .coarseGainOn(coarseGainOn), .fineGainSteps(fineGainSteps)
);
`default_nettype wire

// [reg_host.sv]
// host side model: drives whole configuration words on the register port
// assumes the caller waits out reset; address and data scramble when idle
`timescale 1ns/1ps
`default_nettype none
module reg_host (
  input  wire logic        clk,
  output logic      [3:0]  regAddr,
  output logic      [31:0] regWdata,
  output logic             regWr,
  output logic             regRd
);
  initial begin
    regAddr = 4'h0;
    regWdata = 32'h0000_0000;
    regWr = 1'b0;
    regRd = 1'b0;
  end
  // one strobe carries the whole word, never a partial field
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
    regAddr <= ~a;
    regWdata <= ~d;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    regAddr <= ~a;
  endtask : rd
endmodule : reg_host
`default_nettype wire

// [tb_noise_shaping_gain_control.sv]
// self-checking bench for the noise-shaping and gain control block
// assumes reg_host model and the bound checker are compiled alongside
`timescale 1ns/1ps
`default_nettype none
module tb_noise_shaping_gain_control;
  logic        clk, rst_b, regWr, regRd, sampleClk, prevS, rdSeen;
  logic [3:0]  regAddr, cornerFirst, cornerSecond, fineGainSteps;
  logic [31:0] regWdata, regRdata;
  logic [10:0] adcIn, dataOut, troughCenter;
  logic        dataValid, dataShaped, shapingActive, coarseGainOn, lastSh;
  logic [10:0] smp [0:4095];
  logic [31:0] rdQ [$];
  int error_cnt = 0, comparisons = 0, edgeCnt = 0, ph = 0;
  int seed = 32'h1daa;
  int cornT [16] = '{250, 270, 290, 311, 333, 357, 385, 420,
                     0, 80, 115, 143, 167, 189, 210, 230};
  wire logic edgeDet = sampleClk & ~prevS;
  noise_shaping_gain_control noise_shaping_gain_control_inst (
    .clk(clk), .rst_b(rst_b), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .sampleClk(sampleClk), .adcIn(adcIn), .dataOut(dataOut),
    .dataValid(dataValid), .dataShaped(dataShaped),
    .shapingActive(shapingActive), .cornerFirst(cornerFirst),
    .cornerSecond(cornerSecond), .troughCenter(troughCenter),
    .coarseGainOn(coarseGainOn), .fineGainSteps(fineGainSteps));
  reg_host reg_host_inst (.clk(clk), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd));
  task automatic chkWord(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t word got %h exp %h", $time, got, exp);
    end
  endtask : chkWord
  task automatic chkSmp(input logic [10:0] got, input logic [10:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t sample got %h exp %h", $time, got, exp);
    end
  endtask : chkSmp
  task automatic rdx(input logic [3:0] a, input logic [31:0] e);
    rdQ.push_back(e);
    reg_host_inst.rd(a);
  endtask : rdx
  task automatic test_done();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // compare before counting: a valid seen now belongs to the previous edge
  always @(posedge clk) begin
    if (rdSeen === 1'b1) chkWord(regRdata, rdQ.pop_front());
    rdSeen = regRd;
    if (dataValid === 1'b1 && edgeCnt > 20) begin
      // the sample at a mode switch is repeated or skipped, so not judged
      if (dataShaped === lastSh)
        chkSmp(dataOut, smp[edgeCnt - (dataShaped ? 15 : 14)]);
      lastSh = dataShaped;
    end
    if (edgeDet) begin
      edgeCnt = edgeCnt + 1;
      smp[edgeCnt] = adcIn;
      adcIn <= 11'($random(seed));
    end
    ph = (ph + 1) % 4;
    sampleClk <= (ph >= 2);
    prevS <= sampleClk;
  end
  initial begin
    #100000;
    error_cnt++;
    test_done();
  end
  initial begin
    rst_b = 1'b0;
    sampleClk = 1'b0;
    prevS = 1'b0;
    rdSeen = 1'b0;
    lastSh = 1'b0;
    adcIn = 11'h000;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    rdx(noise_shaping_gain_control_pkg::ADDR_STATUS, 32'h0001_F4E0);
    rdx(noise_shaping_gain_control_pkg::ADDR_FINE, 32'h0000_0000);
    chkWord(32'({coarseGainOn, fineGainSteps}), 32'h0000_0000);
    for (int i = 0; i < 16; i++) begin
      reg_host_inst.wr(noise_shaping_gain_control_pkg::ADDR_CORNER,
                       {24'h0, 4'(15 - i), 4'(i)});
      rdx(noise_shaping_gain_control_pkg::ADDR_STATUS,
          {13'h0, 11'(cornT[i] + cornT[15 - i]), 8'hE0});
      chkWord(32'({cornerSecond, cornerFirst, troughCenter}),
              32'({4'(15 - i), 4'(i), 11'(cornT[i] + cornT[15 - i])}));
    end
    reg_host_inst.wr(noise_shaping_gain_control_pkg::ADDR_STATUS, 32'h0000_FFFF);
    rdx(noise_shaping_gain_control_pkg::ADDR_STATUS, 32'h0001_E0E0);
    rdx(4'hA, 32'h0000_0000);
    for (int i = 0; i < 16; i++) begin
      reg_host_inst.wr(noise_shaping_gain_control_pkg::ADDR_FINE, 32'(i));
      rdx(noise_shaping_gain_control_pkg::ADDR_FINE, (i > 12) ? 12 : i);
    end
    reg_host_inst.wr(noise_shaping_gain_control_pkg::ADDR_CTRL, 32'h0000_0002);
    #1 chkWord(32'(coarseGainOn), 32'h0000_0001);
    reg_host_inst.wr(noise_shaping_gain_control_pkg::ADDR_CTRL, 32'h0000_0001);
    reg_host_inst.wr(noise_shaping_gain_control_pkg::ADDR_CTRL, 32'h0000_0000);
    repeat (6) @(posedge clk iff edgeDet);
    #1 chkWord(32'({coarseGainOn, shapingActive}), 32'h0000_0000);
    @(posedge clk iff edgeDet);
    reg_host_inst.wr(noise_shaping_gain_control_pkg::ADDR_CTRL, 32'h0000_0001);
    repeat (3) @(posedge clk iff edgeDet);
    #1 chkWord(32'(shapingActive), 32'h0000_0000);
    @(posedge clk iff edgeDet);
    @(posedge clk);
    #1 chkWord(32'(shapingActive), 32'h0000_0001);
    repeat (20) @(posedge clk iff edgeDet);
    rdx(noise_shaping_gain_control_pkg::ADDR_STATUS, 32'h0001_E0F1);
    @(posedge clk iff edgeDet);
    reg_host_inst.wr(noise_shaping_gain_control_pkg::ADDR_CTRL, 32'h0000_0000);
    #1 chkWord(32'(shapingActive), 32'h0000_0001);
    @(posedge clk iff edgeDet);
    #1 chkWord(32'(shapingActive), 32'h0000_0000);
    repeat (20) @(posedge clk iff edgeDet);
    repeat (4) @(posedge clk);
    test_done();
  end
endmodule : tb_noise_shaping_gain_control
`default_nettype wire
